// *** rtl/fam_access_ctrl.sv ***
// Flash mode decode, area mapping, command decode and serial programmer link.
module fam_access_ctrl (
    // System clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode pins
    input wire logic mode_select_pin_0,
    input wire logic mode_select_pin_1,
    input wire logic serial_sel_pin,
    // CPU side
    input wire fam_pkg::fam_bus_req_type cpu_req,
    input wire logic reprog_sel_wr,
    input wire logic reprog_sel_data,
    input wire logic user_area_sel,
    // Parallel programmer side
    input wire fam_pkg::fam_bus_req_type par_req,
    // Read mapping result
    output fam_pkg::fam_map_type rd_map,
    // Flash sequencer side
    input wire logic flash_busy,
    output fam_pkg::fam_flash_op_type flash_op,
    output fam_pkg::fam_read_mode_type read_mode,
    output logic clear_status,
    output logic cmd_error,
    // Mode status
    output fam_pkg::fam_mode_type op_mode,
    output logic reprog_active,
    // Serial programmer link
    input wire logic sclk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic ready_busy_flag,
    // Serial byte port to the CPU
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte
);

    // ------------------------------------------------------------------
    // Mode pin capture
    // ------------------------------------------------------------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [1:0] cap_cnt;
    fam_pkg::fam_mode_type pin_mode;
    wire cap_now = (cap_cnt == fam_pkg::CAPTURE_WAIT) && (op_mode == fam_pkg::MODE_INIT);

    assign pin_mode = !pin_sync[0] ?
        (pin_sync[1] ? fam_pkg::MODE_BOOT : fam_pkg::MODE_NORMAL) :
        (pin_sync[2] ? fam_pkg::MODE_SERIAL : fam_pkg::MODE_PARALLEL);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {serial_sel_pin, mode_select_pin_1, mode_select_pin_0};
            pin_sync <= pin_meta;
        end
    end

    // The pins settle through the synchroniser before the one capture.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt <= 2'h0;
            op_mode <= fam_pkg::MODE_INIT;
        end else begin
            if (cap_cnt != fam_pkg::CAPTURE_WAIT) begin
                cap_cnt <= cap_cnt + 2'h1;
            end
            if (cap_now) begin
                op_mode <= pin_mode;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode qualifiers and reprogramming select
    // ------------------------------------------------------------------
    logic reprog_arm;
    wire par_mode = (op_mode == fam_pkg::MODE_PARALLEL);
    wire cpu_mode = (op_mode == fam_pkg::MODE_NORMAL) || (op_mode == fam_pkg::MODE_BOOT)
        || (op_mode == fam_pkg::MODE_SERIAL);
    wire boot_vis = (op_mode == fam_pkg::MODE_BOOT) && !user_area_sel;

    // Entry needs a 0 then a 1; an already set bit survives a lone 1.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reprog_arm <= 1'b0;
            reprog_active <= 1'b0;
        end else if (!cpu_mode) begin
            reprog_arm <= 1'b0;
            reprog_active <= 1'b0;
        end else if (reprog_sel_wr) begin
            reprog_arm <= ~reprog_sel_data;
            reprog_active <= reprog_sel_data & (reprog_arm | reprog_active);
        end
    end

    // ------------------------------------------------------------------
    // Area decode
    // ------------------------------------------------------------------
    wire [15:0] acc_addr = par_mode ? par_req.addr : cpu_req.addr;
    wire [15:0] acc_data = par_mode ? par_req.data : cpu_req.data;
    wire [7:0] code = acc_data[7:0];
    wire par_boot = (acc_addr <= fam_pkg::BOOT_PAR_TOP);
    wire cpu_boot = boot_vis && (acc_addr >= fam_pkg::BOOT_CPU_BASE);
    wire tgt_boot = par_mode ? par_boot : cpu_boot;
    wire [15:0] tgt_ofs = (tgt_boot && !par_mode) ?
        acc_addr - fam_pkg::BOOT_CPU_BASE : acc_addr;
    wire tgt_range = tgt_boot || (acc_addr >= fam_pkg::USER_BASE);
    wire wr_allowed = tgt_range && (!tgt_boot || par_mode);

    wire rd_v = par_mode ? (par_req.valid && !par_req.write) :
        (cpu_mode && cpu_req.valid && !cpu_req.write);
    wire rd_rej = !tgt_range || reprog_active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_map <= '0;
        end else begin
            rd_map.ok <= rd_v && !rd_rej;
            rd_map.reject <= rd_v && rd_rej;
            rd_map.boot <= rd_v && tgt_boot;
            rd_map.offset <= tgt_ofs;
        end
    end

    // ------------------------------------------------------------------
    // Command decoder
    // ------------------------------------------------------------------
    fam_pkg::fam_cmd_state_type state;
    fam_pkg::fam_cmd_state_type next_state;
    fam_pkg::fam_flash_op_type next_op;
    fam_pkg::fam_read_mode_type next_rmode;
    logic next_clear;
    logic next_err;

    // CPU commands count only at even addresses while reprogramming.
    wire cmd_v = par_mode ? (par_req.valid && par_req.write) :
        (reprog_active && cpu_req.valid && cpu_req.write && !cpu_req.addr[0]);
    wire cmd_take = cmd_v && !flash_busy;

    always_comb begin
        next_state = state;
        next_op = '0;
        next_op.boot = tgt_boot;
        next_op.offset = tgt_ofs;
        next_op.data = acc_data;
        next_rmode = read_mode;
        next_clear = 1'b0;
        next_err = 1'b0;
        if (cmd_take) begin
            case (state)
                fam_pkg::CMD_IDLE: begin
                    case (code)
                        fam_pkg::CMD_READ_ARRAY: next_rmode = fam_pkg::RD_ARRAY;
                        fam_pkg::CMD_READ_STATUS: next_rmode = fam_pkg::RD_STATUS;
                        fam_pkg::CMD_CLEAR_STATUS: next_clear = 1'b1;
                        fam_pkg::CMD_PROGRAM: next_state = fam_pkg::CMD_PROG_DATA;
                        fam_pkg::CMD_ERASE: next_state = fam_pkg::CMD_ERASE_CONF;
                        default: next_err = 1'b1;
                    endcase
                end
                fam_pkg::CMD_PROG_DATA: begin
                    next_state = fam_pkg::CMD_IDLE;
                    next_rmode = fam_pkg::RD_STATUS;
                    next_op.valid = wr_allowed;
                    next_op.op = fam_pkg::OP_PROGRAM;
                    next_err = !wr_allowed;
                end
                fam_pkg::CMD_ERASE_CONF: begin
                    next_state = fam_pkg::CMD_IDLE;
                    next_rmode = fam_pkg::RD_STATUS;
                    if (code == fam_pkg::CMD_ERASE_CONFIRM) begin
                        // The boot area erases as one block.
                        next_op.valid = wr_allowed;
                        next_op.op = fam_pkg::OP_BLOCK_ERASE;
                        next_err = !wr_allowed;
                    end else if (code == fam_pkg::CMD_ERASE) begin
                        // Outside parallel mode erase-all spares the boot area.
                        next_op.valid = 1'b1;
                        next_op.op = fam_pkg::OP_ERASE_ALL;
                        next_op.boot = par_mode;
                    end else begin
                        next_err = 1'b1;
                    end
                end
                default: next_state = fam_pkg::CMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fam_pkg::CMD_IDLE;
            flash_op <= '0;
            read_mode <= fam_pkg::RD_ARRAY;
            clear_status <= 1'b0;
            cmd_error <= 1'b0;
        end else begin
            state <= next_state;
            flash_op <= next_op;
            read_mode <= next_rmode;
            clear_status <= next_clear;
            cmd_error <= next_err;
        end
    end

    // ------------------------------------------------------------------
    // Serial link crossing and busy flag
    // ------------------------------------------------------------------
    logic tx_pend;
    logic [7:0] tx_hold;
    logic [7:0] link_word;
    logic link_sent;
    logic link_tgl;
    logic link_act;
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_seen;
    logic act_meta;
    logic act_sync;
    wire rx_evt = tgl_sync ^ tgl_seen;

    assign tx_ready = ~tx_pend;
    assign sda_out = 1'b0;

    fam_ser_link u_link (
        .sclk(sclk),
        .rst_n(rst_n),
        .sda_in(sda_in),
        .sda_oe(sda_oe),
        .tx_pend(tx_pend),
        .tx_byte(tx_hold),
        .rx_word(link_word),
        .rx_sent(link_sent),
        .rx_tgl(link_tgl),
        .active(link_act)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_meta <= 1'b0;
            tgl_sync <= 1'b0;
            tgl_seen <= 1'b0;
            act_meta <= 1'b0;
            act_sync <= 1'b0;
        end else begin
            tgl_meta <= link_tgl;
            tgl_sync <= tgl_meta;
            tgl_seen <= tgl_sync;
            act_meta <= link_act;
            act_sync <= act_meta;
        end
    end

    // The link word is stable once its toggle has crossed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pend <= 1'b0;
            tx_hold <= 8'h00;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            ready_busy_flag <= 1'b0;
        end else begin
            rx_valid <= rx_evt;
            if (rx_evt) begin
                rx_byte <= link_word;
            end
            if (tx_valid && tx_ready) begin
                tx_pend <= 1'b1;
                tx_hold <= tx_byte;
            end else if (rx_evt && link_sent) begin
                tx_pend <= 1'b0;
            end
            ready_busy_flag <= flash_busy | act_sync | tx_pend;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sel_zero;
        reprog_sel_wr && !reprog_sel_data;
    endsequence

    sequence s_sel_one;
        reprog_sel_wr && reprog_sel_data;
    endsequence

    a_normal_no_boot: assert property (
        op_mode == fam_pkg::MODE_NORMAL && rd_map.ok |-> !rd_map.boot)
        else $error("Boot area read in normal mode.");

    a_mode_capture: assert property (
        cap_now |=> op_mode == $past(pin_mode) ##1 $stable(op_mode)[*8])
        else $error("Mode not captured or not held.");

    a_par_boot_map: assert property (
        par_mode && par_req.valid && !par_req.write && par_req.addr <= fam_pkg::BOOT_PAR_TOP
        |=> rd_map.ok && rd_map.boot && rd_map.offset == $past(acc_addr))
        else $error("Parallel boot address mapped wrongly.");

    a_cpu_boot_map: assert property (
        op_mode == fam_pkg::MODE_BOOT && !user_area_sel && !reprog_active && cpu_req.valid
        && !cpu_req.write && cpu_req.addr >= fam_pkg::BOOT_CPU_BASE
        |=> rd_map.ok && rd_map.boot
        && rd_map.offset == 16'($past(acc_addr) - fam_pkg::BOOT_CPU_BASE))
        else $error("CPU boot address mapped wrongly.");

    a_boot_write_par: assert property (
        flash_op.valid && flash_op.boot && flash_op.op != fam_pkg::OP_ERASE_ALL
        |-> op_mode == fam_pkg::MODE_PARALLEL)
        else $error("Boot area write outside parallel mode.");

    a_cpu_user_only: assert property (
        flash_op.valid && cpu_mode |-> !flash_op.boot)
        else $error("CPU reprogramming reached the boot area.");

    a_serial_no_boot: assert property (
        op_mode == fam_pkg::MODE_SERIAL |-> !rd_map.boot && !(flash_op.valid && flash_op.boot))
        else $error("Boot area reached in serial mode.");

    a_reprog_no_fetch: assert property (
        reprog_active && cpu_req.valid && !cpu_req.write |=> rd_map.reject && !rd_map.ok)
        else $error("Flash read allowed while reprogramming.");

    a_sel_enter: assert property (
        (cpu_mode and s_sel_zero) ##1 s_sel_one |=> reprog_active)
        else $error("Reprogramming not entered after 0 then 1.");

    a_sel_clear: assert property (
        s_sel_zero |=> !reprog_active)
        else $error("Reprogramming not left after a 0.");

    a_busy_flash: assert property (
        flash_busy |=> ready_busy_flag)
        else $error("Busy low during a flash operation.");

    a_busy_idle: assert property (
        !flash_busy && !act_sync && !tx_pend |=> !ready_busy_flag)
        else $error("Busy high while idle.");

    a_cmd_prog: assert property (
        state == fam_pkg::CMD_IDLE && cmd_take && code == fam_pkg::CMD_PROGRAM
        |=> state == fam_pkg::CMD_PROG_DATA ##1 !flash_op.valid)
        else $error("Program code not decoded.");

endmodule // fam_access_ctrl

// *** rtl/fam_ser_link.sv ***
// Serial programmer link shift logic running on the programmer's clock.
module fam_ser_link (
    // Link clock and reset
    input wire logic sclk,
    input wire logic rst_n,
    // Pin side
    input wire logic sda_in,
    output logic sda_oe,
    // System side, held stable by the parent while pending
    input wire logic tx_pend,
    input wire logic [7:0] tx_byte,
    // Received frame, stable after its toggle
    output logic [7:0] rx_word,
    output logic rx_sent,
    output logic rx_tgl,
    output logic active
);
    logic pend_meta;
    logic pend_sync;
    logic tx_on;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    wire last_bit = (bit_cnt == fam_pkg::LINK_LAST_BIT);
    wire [2:0] tx_idx = fam_pkg::LINK_LAST_BIT - bit_cnt;

    // Only the low level is driven; the pull-up gives the high level.
    assign sda_oe = tx_on & ~tx_byte[tx_idx];

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_meta <= 1'b0;
            pend_sync <= 1'b0;
        end else begin
            pend_meta <= tx_pend;
            pend_sync <= pend_meta;
        end
    end

    // A frame is eight edges; the transmit choice changes only between frames.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
            tx_on <= 1'b0;
            rx_word <= 8'h00;
            rx_sent <= 1'b0;
            rx_tgl <= 1'b0;
            active <= 1'b0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_shift <= {rx_shift[6:0], sda_in};
            active <= ~last_bit;
            if (last_bit) begin
                rx_word <= {rx_shift[6:0], sda_in};
                rx_sent <= tx_on;
                rx_tgl <= ~rx_tgl;
                tx_on <= pend_sync & ~tx_on;
            end
        end
    end

endmodule // fam_ser_link

// *** shared/fam_pkg.sv ***
// Shared constants and types of the flash mode and area access control.
package fam_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [15:0] BOOT_PAR_BASE = 16'h0000;
    localparam logic [15:0] BOOT_PAR_TOP = 16'h1fff;
    localparam logic [15:0] BOOT_CPU_BASE = 16'he000;
    localparam logic [15:0] BOOT_CPU_TOP = 16'hffff;
    localparam logic [15:0] USER_BASE = 16'h2000;

    // ------------------------------------------------------------------
    // First and second cycle command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;

    // ------------------------------------------------------------------
    // Timing and link
    // ------------------------------------------------------------------
    localparam logic [1:0] CAPTURE_WAIT = 2'h2;
    localparam logic [2:0] LINK_LAST_BIT = 3'h7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_INIT, MODE_NORMAL, MODE_BOOT, MODE_PARALLEL, MODE_SERIAL
    } fam_mode_type;

    typedef enum logic [2:0] {
        OP_NONE, OP_PROGRAM, OP_BLOCK_ERASE, OP_ERASE_ALL
    } fam_op_type;

    typedef enum logic [1:0] {CMD_IDLE, CMD_PROG_DATA, CMD_ERASE_CONF} fam_cmd_state_type;

    typedef enum logic {RD_ARRAY, RD_STATUS} fam_read_mode_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } fam_bus_req_type;

    typedef struct packed {
        logic ok;
        logic reject;
        logic boot;
        logic [15:0] offset;
    } fam_map_type;

    typedef struct packed {
        logic valid;
        fam_op_type op;
        logic boot;
        logic [15:0] offset;
        logic [15:0] data;
    } fam_flash_op_type;

endpackage

// *** testbench/fam_ser_prog.sv ***
// Serial programmer model that clocks the link and moves bytes on the data pin.
module fam_ser_prog (
    // Link pins
    output logic sclk,
    output logic sda_drv,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b0;
        sda_drv = 1'b1;
    end

    // The clock stands low between frames and the pin is released to its pull-up.
    // The device moves its data pin after each rising edge, so a bit is read just before one.
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        #7;
        for (int i = 7; i >= 0; i--) begin
            sda_drv = tx[i];
            #62.5;
            rx[i] = sda_line;
            sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        sda_drv = 1'b1;
    endtask
endmodule // fam_ser_prog

// *** testbench/test_flash_mode_area_access_control.sv ***
// Self-checking bench for the flash mode and area access control.
module test_flash_mode_area_access_control;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, flash_busy = 1'b0, tx_valid = 1'b0, user_area_sel = 1'b0;
    logic mode_select_pin_0 = 1'b0, mode_select_pin_1 = 1'b0, serial_sel_pin = 1'b0;
    logic reprog_sel_wr = 1'b0, reprog_sel_data = 1'b0;
    fam_pkg::fam_bus_req_type cpu_req = '0, par_req = '0;
    logic [7:0] tx_byte = 8'h00, rnd = 8'h26, rx_seen, cap, rx_byte;
    fam_pkg::fam_map_type rd_map;
    fam_pkg::fam_flash_op_type flash_op;
    fam_pkg::fam_read_mode_type read_mode;
    fam_pkg::fam_mode_type op_mode;
    logic clear_status, cmd_error, reprog_active, sclk, sda_in, sda_out, sda_oe;
    logic ready_busy_flag, tx_ready, rx_valid, sda_drv;
    int miscompares = 0, checks = 0, rx_count = 0;

    always #12.5 clk = ~clk;
    assign sda_in = (sda_oe ? sda_out : 1'b1) & sda_drv;

    always @(posedge clk) begin
        if (rx_valid) begin
            rx_count <= rx_count + 1;
            rx_seen <= rx_byte;
        end
    end

    fam_access_ctrl fam_access_ctrl_i (
        .clk, .rst_n, .mode_select_pin_0, .mode_select_pin_1, .serial_sel_pin,
        .cpu_req, .reprog_sel_wr, .reprog_sel_data, .user_area_sel, .par_req, .rd_map,
        .flash_busy, .flash_op, .read_mode, .clear_status, .cmd_error, .op_mode,
        .reprog_active, .sclk, .sda_in, .sda_out, .sda_oe, .ready_busy_flag,
        .tx_valid, .tx_byte, .tx_ready, .rx_valid, .rx_byte
    );
    fam_ser_prog fam_ser_prog_i (.sclk, .sda_drv, .sda_line(sda_in));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] rnd8();
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        return rnd;
    endfunction

    // Even user address well clear of the reserved programmer range.
    function automatic logic [15:0] user_addr();
        logic [7:0] hi = rnd8();
        logic [7:0] lo = rnd8();
        return {2'b01, hi[5:0], lo[7:1], 1'b0};
    endfunction

    function automatic logic [15:0] cpu_boot_off(input logic [15:0] a);
        return a - fam_pkg::BOOT_CPU_BASE;
    endfunction

    task automatic do_reset(input logic p0, input logic p1, input logic ss);
        rst_n <= 1'b0;
        mode_select_pin_0 <= p0;
        mode_select_pin_1 <= p1;
        serial_sel_pin <= ss;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic req(input logic par, input logic w, input logic [15:0] a, input logic [15:0] d);
        fam_pkg::fam_bus_req_type r;
        r = {1'b1, w, a, d};
        @(posedge clk);
        par_req <= par ? r : '0;
        cpu_req <= par ? '0 : r;
        @(posedge clk);
        par_req <= '0;
        cpu_req <= '0;
        #1;
    endtask

    task automatic sel(input logic v);
        @(posedge clk);
        reprog_sel_wr <= 1'b1;
        reprog_sel_data <= v;
        @(posedge clk);
        reprog_sel_wr <= 1'b0;
        #1;
    endtask

    // Two select writes on consecutive cycles, 0 then 1.
    task automatic sel_pair();
        @(posedge clk);
        reprog_sel_wr <= 1'b1;
        reprog_sel_data <= 1'b0;
        @(posedge clk);
        reprog_sel_data <= 1'b1;
        @(posedge clk);
        reprog_sel_wr <= 1'b0;
        #1;
    endtask

    task automatic byte_frame(input logic [7:0] b);
        int n0 = rx_count;
        fam_ser_prog_i.frame(b, cap);
        for (int i = 0; i < 40 && rx_count == n0; i++) @(posedge clk);
        if (rx_count == n0) begin
            miscompares++;
            $display("mismatch at %0t: no received byte", $time);
            report_and_stop();
        end
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] a, d;
        logic [7:0] b;
        do_reset(1'b0, 1'b1, 1'b0);
        chk(op_mode, fam_pkg::MODE_BOOT, "boot mode");
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 16'he000 : (i == 1) ? 16'hffff : {3'b111, 13'({rnd8(), rnd8()})};
            req(1'b0, 1'b0, a, 16'h0000);
            chk({rd_map.ok, rd_map.boot, rd_map.offset}, {2'b11, cpu_boot_off(a)}, "boot read");
        end
        req(1'b0, 1'b0, 16'h1ffe, 16'h0000);
        chk(rd_map.reject, 1'b1, "low read");
        @(posedge clk);
        user_area_sel <= 1'b1;
        req(1'b0, 1'b0, 16'he010, 16'h0000);
        chk({rd_map.ok, rd_map.boot}, 2'b10, "user select");
        @(posedge clk);
        user_area_sel <= 1'b0;
        sel(1'b1);
        chk(reprog_active, 1'b0, "lone set");
        sel(1'b0);
        sel(1'b1);
        chk(reprog_active, 1'b1, "set pair");
        req(1'b0, 1'b0, 16'he010, 16'h0000);
        chk(rd_map.reject, 1'b1, "read in reprog");
        req(1'b0, 1'b1, 16'h0000, 16'h0040);
        req(1'b0, 1'b1, 16'he010, 16'h1234);
        chk({flash_op.valid, cmd_error}, 2'b01, "boot program");
        a = user_addr();
        d = {rnd8(), rnd8()};
        req(1'b0, 1'b1, 16'h0000, 16'h0040);
        req(1'b0, 1'b1, a, d);
        chk(flash_op, {1'b1, fam_pkg::OP_PROGRAM, 1'b0, a, d}, "user program");
        sel(1'b0);
        chk(reprog_active, 1'b0, "clear");
        $display("test boot done");

        do_reset(1'b0, 1'b0, 1'b0);
        chk(op_mode, fam_pkg::MODE_NORMAL, "normal mode");
        req(1'b0, 1'b0, 16'he010, 16'h0000);
        chk({rd_map.ok, rd_map.boot}, 2'b10, "normal read");
        sel_pair();
        chk(reprog_active, 1'b1, "set back to back");
        a = user_addr();
        req(1'b0, 1'b1, 16'h0000, 16'h0040);
        req(1'b0, 1'b1, a, 16'h5a5a);
        chk(flash_op, {1'b1, fam_pkg::OP_PROGRAM, 1'b0, a, 16'h5a5a}, "normal program");
        $display("test normal done");

        do_reset(1'b1, 1'b0, 1'b0);
        chk(op_mode, fam_pkg::MODE_PARALLEL, "parallel mode");
        a = {3'b000, 12'({rnd8(), rnd8()}), 1'b0};
        req(1'b1, 1'b0, a, 16'h0000);
        chk({rd_map.ok, rd_map.boot, rd_map.offset}, {2'b11, a}, "par read");
        req(1'b1, 1'b1, 16'h0000, 16'h0070);
        chk(read_mode, fam_pkg::RD_STATUS, "status");
        req(1'b1, 1'b1, 16'h0000, 16'h00ff);
        chk(read_mode, fam_pkg::RD_ARRAY, "array");
        req(1'b1, 1'b1, 16'h0000, 16'h0050);
        chk(clear_status, 1'b1, "clear status");
        req(1'b1, 1'b1, 16'h0000, 16'h0033);
        chk(cmd_error, 1'b1, "bad code");
        d = {rnd8(), rnd8()};
        req(1'b1, 1'b1, 16'h0000, 16'h0040);
        req(1'b1, 1'b1, a, d);
        chk(flash_op, {1'b1, fam_pkg::OP_PROGRAM, 1'b1, a, d}, "par program");
        req(1'b1, 1'b1, 16'h0000, 16'h0020);
        req(1'b1, 1'b1, 16'h1ffe, 16'h00d0);
        chk({flash_op.valid, flash_op.op, flash_op.boot}, {1'b1, fam_pkg::OP_BLOCK_ERASE, 1'b1},
            "block erase");
        req(1'b1, 1'b1, 16'h0000, 16'h0020);
        req(1'b1, 1'b1, 16'h0000, 16'h0020);
        chk({flash_op.valid, flash_op.op}, {1'b1, fam_pkg::OP_ERASE_ALL}, "erase all");
        @(posedge clk);
        flash_busy <= 1'b1;
        req(1'b1, 1'b1, 16'h0000, 16'h00ff);
        chk({ready_busy_flag, read_mode}, {1'b1, fam_pkg::RD_STATUS}, "busy");
        @(posedge clk);
        flash_busy <= 1'b0;
        req(1'b1, 1'b1, 16'h0000, 16'h00ff);
        chk(read_mode, fam_pkg::RD_ARRAY, "after busy");
        $display("test parallel done");

        do_reset(1'b1, 1'b0, 1'b1);
        chk(op_mode, fam_pkg::MODE_SERIAL, "serial mode");
        req(1'b0, 1'b0, 16'he010, 16'h0000);
        chk(rd_map.boot, 1'b0, "serial read");
        sel(1'b0);
        sel(1'b1);
        req(1'b0, 1'b1, 16'h0000, 16'h0040);
        req(1'b0, 1'b1, 16'he010, 16'h0102);
        chk({flash_op.valid, flash_op.boot}, 2'b10, "serial program");
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd8();
            byte_frame(b);
            chk(rx_seen, b, "rx byte");
        end
        b = rnd8();
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_byte <= b;
        @(posedge clk);
        tx_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk({tx_ready, ready_busy_flag}, 2'b01, "tx pending");
        byte_frame(rnd8());
        byte_frame(8'hff);
        chk(cap, b, "tx byte");
        repeat (10) @(posedge clk);
        #1;
        chk({tx_ready, ready_busy_flag, sda_oe}, 3'b100, "idle");
        $display("test serial done");
        report_and_stop();
    end
endmodule // test_flash_mode_area_access_control
